// [mobl_exec.sv]
// execution unit for or/move/pointer-load/memory-move/bank-load
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mobl_exec
   import mobl_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // apb slave request
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   // apb slave answer
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   mobl_state_t state_ff;
   mobl_dec_t ir_ff;
   mobl_dec_t dec;
   mobl_mem_t mem;
   logic [7:0] w_ff, bank_ff, hold_ff, mem_rdata, operand, result;
   logic [11:0] ptr_ff [3];
   logic [11:0] dst_ff, daddr_ff;
   logic [15:0] last_word_ff;
   logic z_ff, n_ff, err_ff, src_w_ff, pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, nxt_prdata;
   logic nxt_slverr, setup, wr_acc, instr_wr, word2_ok, busy;
   logic exec_file, exec_to_w, mm_to_w;

   // decode the word offered on the bus
   mobl_decode u_decode (
      .word(PWDATA[15:0]),
      .bank(bank_ff),
      .dec(dec)
   );

   // data space storage
   mobl_dmem u_dmem (
      .clk(CLK),
      .port(mem),
      .rdata(mem_rdata)
   );

   // bus phase qualifiers
   assign setup = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PWRITE && pready_ff && !pslverr_ff;
   assign instr_wr = wr_acc && PADDR == A_INSTR;
   assign busy = state_ff != S_IDLE;

   // second word check
   assign word2_ok = (ir_ff.op == OP_MMOVE && PWDATA[15:12] == OPC_MM2)
      || (ir_ff.op == OP_PLOAD && PWDATA[15:8] == OPC_PTR2);

   // operand and alu result
   assign operand = src_w_ff ? w_ff : mem_rdata;
   assign result = (ir_ff.op == OP_IOR) ? (w_ff | operand) : operand;

   // which core register or memory byte gets the result
   assign exec_file = state_ff == S_EXEC && ir_ff.dest_f
      && (ir_ff.op == OP_IOR || ir_ff.op == OP_FMOVE);
   assign exec_to_w = state_ff == S_EXEC && (ir_ff.op == OP_IOR
      || ir_ff.op == OP_FMOVE)
      && (!ir_ff.dest_f || ir_ff.addr == WREG_ADDR);
   assign mm_to_w = state_ff == S_EXEC2 && ir_ff.op == OP_MMOVE
      && dst_ff == WREG_ADDR;

   // data memory port steering
   always_comb begin
      mem = '0;
      if (state_ff == S_IDLE && instr_wr) begin
         mem.addr = dec.addr; // source read of the first cycle
      end else if (exec_file && ir_ff.addr != WREG_ADDR) begin
         mem.we = 1'b1;
         mem.addr = ir_ff.addr;
         mem.wdata = result;
      end else if (state_ff == S_EXEC2 && ir_ff.op == OP_MMOVE) begin
         mem.we = dst_ff != WREG_ADDR;
         mem.addr = dst_ff;
         mem.wdata = hold_ff;
      end else if (wr_acc && PADDR == A_DDATA) begin
         mem.we = 1'b1;
         mem.addr = daddr_ff;
         mem.wdata = PWDATA[7:0];
      end
   end

   // instruction sequencer
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_ff <= S_IDLE;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (instr_wr) begin
                  state_ff <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (ir_ff.op == OP_PLOAD || ir_ff.op == OP_MMOVE) begin
                  state_ff <= S_WORD2;
               end else begin
                  state_ff <= S_IDLE;
               end
            end
            S_WORD2: begin
               if (instr_wr) begin
                  state_ff <= word2_ok ? S_EXEC2 : S_IDLE;
               end
            end
            S_EXEC2: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // latched instruction, second word and source data
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ir_ff <= '0;
         dst_ff <= PTR_RST;
         hold_ff <= BYTE_RST;
         src_w_ff <= 1'b0;
         last_word_ff <= '0;
      end else begin
         if (instr_wr) begin
            last_word_ff <= PWDATA[15:0];
         end
         if (state_ff == S_IDLE && instr_wr) begin
            ir_ff <= dec;
            src_w_ff <= dec.addr == WREG_ADDR;
         end
         if (state_ff == S_WORD2 && instr_wr) begin
            dst_ff <= PWDATA[11:0];
         end
         if (state_ff == S_EXEC && ir_ff.op == OP_MMOVE) begin
            hold_ff <= operand;
         end
      end
   end

   // working register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         w_ff <= BYTE_RST;
      end else if (exec_to_w) begin
         w_ff <= result;
      end else if (mm_to_w) begin
         w_ff <= hold_ff;
      end else if (wr_acc && PADDR == A_WREG) begin
         w_ff <= PWDATA[7:0];
      end
   end

   // bank selector register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bank_ff <= BYTE_RST;
      end else if (state_ff == S_EXEC && ir_ff.op == OP_BLOAD) begin
         bank_ff <= ir_ff.lit;
      end else if (wr_acc && PADDR == A_BANK) begin
         bank_ff <= PWDATA[7:0];
      end
   end

   // three pointer registers
   for (genvar i = 0; i < 3; i++) begin : g_ptr
      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            ptr_ff[i] <= PTR_RST;
         end else if (ir_ff.op == OP_PLOAD && ir_ff.sel == 2'(i)
               && state_ff == S_EXEC) begin
            ptr_ff[i][11:8] <= ir_ff.lit[3:0];
         end else if (ir_ff.op == OP_PLOAD && ir_ff.sel == 2'(i)
               && state_ff == S_EXEC2) begin
            ptr_ff[i][7:0] <= dst_ff[7:0];
         end else if (wr_acc && PADDR == A_PTR0 + 8'(4 * i)) begin
            ptr_ff[i] <= PWDATA[11:0];
         end
      end
   end

   // zero and negative flags, error flag
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         z_ff <= 1'b0;
         n_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         if (state_ff == S_EXEC && (ir_ff.op == OP_IOR
               || ir_ff.op == OP_FMOVE)) begin
            z_ff <= result == BYTE_RST;
            n_ff <= result[7];
         end
         if ((state_ff == S_EXEC && ir_ff.op == OP_NONE)
               || (state_ff == S_WORD2 && instr_wr && !word2_ok)) begin
            err_ff <= 1'b1; // a new error wins over the clear
         end else if (wr_acc && PADDR == A_STATUS && PWDATA[ST_ERR]) begin
            err_ff <= 1'b0;
         end
      end
   end

   // memory access address register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         daddr_ff <= PTR_RST;
      end else if (wr_acc && PADDR == A_DADDR) begin
         daddr_ff <= PWDATA[11:0];
      end
   end

   // read data and refusal, prepared in the setup cycle
   always_comb begin
      nxt_prdata = WORD_RST;
      nxt_slverr = 1'b0;
      unique case (PADDR)
         A_INSTR: begin
            nxt_prdata[15:0] = last_word_ff;
            nxt_slverr = PWRITE && (state_ff == S_EXEC
               || state_ff == S_EXEC2);
         end
         A_STATUS: begin
            nxt_prdata[ST_Z] = z_ff;
            nxt_prdata[ST_N] = n_ff;
            nxt_prdata[ST_BUSY] = busy;
            nxt_prdata[ST_ERR] = err_ff;
         end
         A_WREG: nxt_prdata[7:0] = w_ff;
         A_BANK: nxt_prdata[7:0] = bank_ff;
         A_PTR0: nxt_prdata[11:0] = ptr_ff[0];
         A_PTR1: nxt_prdata[11:0] = ptr_ff[1];
         A_PTR2: nxt_prdata[11:0] = ptr_ff[2];
         A_DADDR: nxt_prdata[11:0] = daddr_ff;
         A_DDATA: nxt_slverr = PWRITE && busy;
         default: nxt_slverr = 1'b1;
      endcase
      if (PWRITE && busy && PADDR != A_INSTR && PADDR != A_STATUS) begin
         nxt_slverr = 1'b1;
      end
   end

   // apb answer registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         prdata_ff <= WORD_RST;
         pslverr_ff <= 1'b0;
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (setup) begin
            prdata_ff <= PWRITE ? WORD_RST : nxt_prdata;
            pslverr_ff <= nxt_slverr;
         end
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = pready_ff;
   assign PSLVERR = pslverr_ff;

   // checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_exec(mobl_op_t op);
      state_ff == S_EXEC && ir_ff.op == op;
   endsequence
   sequence s_exec2(mobl_op_t op);
      state_ff == S_EXEC2 && ir_ff.op == op;
   endsequence

   a_bank_load: assert property (s_exec(OP_BLOAD) |=>
      bank_ff == $past(ir_ff.lit) && $stable(z_ff) && $stable(n_ff))
      else $error("bank selector not loaded from literal");
   a_ptr_high: assert property (s_exec(OP_PLOAD) |=>
      state_ff == S_WORD2
      && ptr_ff[$past(ir_ff.sel)][11:8] == $past(ir_ff.lit[3:0]))
      else $error("pointer high nibble not written");
   a_ptr_low: assert property (s_exec2(OP_PLOAD) |=>
      ptr_ff[$past(ir_ff.sel)][7:0] == $past(dst_ff[7:0]))
      else $error("pointer low byte not written");
   a_ptr_sel: assert property (state_ff == S_EXEC
      && ir_ff.op == OP_PLOAD |-> ir_ff.sel <= PTR_LAST)
      else $error("pointer selector out of range");
   a_move_to_w: assert property (state_ff == S_EXEC
      && ir_ff.op == OP_FMOVE && !ir_ff.dest_f |=> w_ff == $past(operand))
      else $error("file move did not reach working register");
   a_flags_set: assert property ((s_exec(OP_IOR)
      or s_exec(OP_FMOVE))
      |=> z_ff == ($past(result) == BYTE_RST) && n_ff == $past(result[7]))
      else $error("zero or negative flag wrong");
   a_mm_first: assert property (s_exec(OP_MMOVE) |-> !mem.we
      ##1 state_ff == S_WORD2 && hold_ff == $past(operand))
      else $error("memory move first cycle wrong");
   a_mm_write: assert property (s_exec2(OP_MMOVE)
      ##0 dst_ff != WREG_ADDR |-> mem.we
      && mem.addr == dst_ff && mem.wdata == hold_ff)
      else $error("memory move destination not written");
endmodule // mobl_exec
`default_nettype wire

// [mobl_pkg.sv]
// constants and types of the move / bank-load execution block
package mobl_pkg;
   // instruction patterns
   localparam logic [5:0] OPC_IOR = 6'h04;
   localparam logic [5:0] OPC_FMOVE = 6'h14;
   localparam logic [9:0] OPC_PTR = 10'h3b8;
   localparam logic [7:0] OPC_PTR2 = 8'hf0;
   localparam logic [3:0] OPC_MM1 = 4'hc;
   localparam logic [3:0] OPC_MM2 = 4'hf;
   localparam logic [7:0] OPC_BANK = 8'h01;
   localparam logic [1:0] PTR_LAST = 2'h2;
   // data space layout
   localparam int DADDR_W = 12;
   localparam int DMEM_DEPTH = 4096;
   localparam logic [7:0] ACC_SPLIT = 8'h80;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   localparam logic [11:0] WREG_ADDR = 12'hfe8;
   // apb register offsets
   localparam logic [7:0] A_INSTR = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_WREG = 8'h08;
   localparam logic [7:0] A_BANK = 8'h0c;
   localparam logic [7:0] A_PTR0 = 8'h10;
   localparam logic [7:0] A_PTR1 = 8'h14;
   localparam logic [7:0] A_PTR2 = 8'h18;
   localparam logic [7:0] A_DADDR = 8'h1c;
   localparam logic [7:0] A_DDATA = 8'h20;
   // status register bits
   localparam int ST_Z = 0;
   localparam int ST_N = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_ERR = 3;
   // reset values
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   // decoded operations
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_IOR = 3'b001,
      OP_FMOVE = 3'b010,
      OP_PLOAD = 3'b011,
      OP_MMOVE = 3'b100,
      OP_BLOAD = 3'b101
   } mobl_op_t;
   // instruction sequencing states
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_EXEC = 2'b01,
      S_WORD2 = 2'b10,
      S_EXEC2 = 2'b11
   } mobl_state_t;
   // decoded first instruction word
   typedef struct packed {
      mobl_op_t op;
      logic dest_f;
      logic [7:0] lit;
      logic [1:0] sel;
      logic [11:0] addr;
   } mobl_dec_t;
   // data memory port
   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } mobl_mem_t;
endpackage

// [mobl_dmem.sv]
// 4096-byte data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mobl_dmem
   import mobl_pkg::*;
(
   // clock
   input wire logic clk,
   // access port
   input wire mobl_mem_t port,
   // read data, one cycle after the address
   output logic [7:0] rdata
);
   logic [7:0] mem [DMEM_DEPTH];

   // write on request, read every cycle
   always_ff @(posedge clk) begin
      if (port.we) begin
         mem[port.addr] <= port.wdata;
      end
      rdata <= mem[port.addr];
   end
endmodule // mobl_dmem
`default_nettype wire

// [mobl_decode.sv]
// decoder for the first word of an instruction
`timescale 1ns/1ps
`default_nettype none
module mobl_decode
   import mobl_pkg::*;
(
   // instruction word and bank selector
   input wire logic [15:0] word,
   input wire logic [7:0] bank,
   // decoded fields
   output mobl_dec_t dec
);
   logic [11:0] file_addr;

   // access bank or banked address of the file operand
   always_comb begin
      if (!word[8]) begin
         if (word[7:0] < ACC_SPLIT) begin
            file_addr = {ACC_LO_BANK, word[7:0]};
         end else begin
            file_addr = {ACC_HI_BANK, word[7:0]};
         end
      end else begin
         file_addr = {bank[3:0], word[7:0]};
      end
   end

   // opcode classification and field extraction
   always_comb begin
      dec = '0;
      dec.lit = word[7:0];
      dec.sel = word[5:4];
      dec.dest_f = word[9];
      dec.addr = file_addr;
      if (word[15:10] == OPC_IOR) begin
         dec.op = OP_IOR;
      end else if (word[15:10] == OPC_FMOVE) begin
         dec.op = OP_FMOVE;
      end else if (word[15:12] == OPC_MM1) begin
         dec.op = OP_MMOVE;
         dec.addr = word[11:0];
      end else if (word[15:6] == OPC_PTR && word[5:4] <= PTR_LAST) begin
         dec.op = OP_PLOAD;
      end else if (word[15:8] == OPC_BANK) begin
         dec.op = OP_BLOAD;
      end
   end
endmodule // mobl_decode
`default_nettype wire

// [mobl_host.sv]
// apb master model standing in for the host software
`timescale 1ns/1ps
`default_nettype none
module mobl_host (
   // clock
   input wire logic clk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hff;
      pwdata = 32'h0000_0000;
   end

   // one transfer: setup, access until pready, answer taken at that edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // mobl_host
`default_nettype wire

// [tb_move_or_bank_load_exec.sv]
// self-checking bench of the move / bank-load execution block
`timescale 1ns/1ps
`default_nettype none
module tb_move_or_bank_load_exec;
   import mobl_pkg::*;
   logic clk;
   logic rst_n;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   int error_cnt, check_count, cycles;
   logic [11:0] ptr [3];
   logic [1:0] st;

   mobl_exec mobl_exec_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   mobl_host mobl_host_i (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // clock and hang guard
   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         error_cnt++;
         $display("Error at %0t: run did not finish", $time);
         finish_test();
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      mobl_host_i.xfer(1'b1, a, d, rd, er);
      chk({31'h0, er}, 32'h0, "write refused");
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input string m);
      mobl_host_i.xfer(1'b0, a, 32'h0, rd, er);
      chk({31'h0, er}, 32'h0, "read refused");
      chk(rd, x, m);
   endtask

   // poll busy under a bound
   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         mobl_host_i.xfer(1'b0, A_STATUS, 32'h0, rd, er);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 20);
      chk({31'h0, rd[ST_BUSY]}, 32'h0, "busy stuck");
   endtask

   task automatic ins2(input logic [15:0] w1, input logic [15:0] w2);
      wr(A_INSTR, {16'h0, w1});
      wr(A_INSTR, {16'h0, w2});
      idle_wait();
   endtask

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
      wr(A_DADDR, {20'h0, a});
      wr(A_DDATA, {24'h0, d});
   endtask

   // memory byte seen through a move into w
   task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
      ins2({OPC_MM1, a}, {OPC_MM2, WREG_ADDR});
      rdc(A_WREG, {24'h0, d}, "memory byte");
   endtask

   // data address of a file operand
   function automatic logic [11:0] eaddr(logic [7:0] f, logic a,
      logic [7:0] b);
      if (a)
         return {b[3:0], f};
      return (f < ACC_SPLIT) ? {ACC_LO_BANK, f} : {ACC_HI_BANK, f};
   endfunction

   initial begin
      logic [7:0] k, f, fv, wv, bk, res, v;
      logic [11:0] kp, s, t, ad;
      logic op, d, a;
      logic [7:0] regs [6];
      int seed;
      regs = '{A_STATUS, A_WREG, A_BANK, A_PTR0, A_PTR1, A_PTR2};
      rst_n = 1'b0;
      error_cnt = 0;
      check_count = 0;
      cycles = 0;
      st = 2'b00;
      ptr = '{12'h000, 12'h000, 12'h000};
      seed = $urandom(32'h3ef2);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // reset values and an unmapped place
      foreach (regs[i]) rdc(regs[i], 32'h0, "reset value");
      mobl_host_i.xfer(1'b0, 8'h40, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1, "unmapped");
      // bank load, flags left alone
      for (int i = 0; i < 8; i++) begin
         k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         ins2({OPC_BANK, k}, {OPC_BANK, k});
         rdc(A_BANK, {24'h0, k}, "bank");
         rdc(A_STATUS, {30'h0, st}, "flags after bank");
      end
      // pointer load, high nibble first then low byte
      for (int i = 0; i < 12; i++) begin
         kp = (i < 3) ? 12'hfff : 12'($urandom);
         wr(A_INSTR, {16'h0, OPC_PTR, 2'(i % 3), kp[11:8]});
         ptr[i % 3][11:8] = kp[11:8];
         rdc(A_PTR0 + 8'(4 * (i % 3)), {20'h0, ptr[i % 3]}, "hi");
         if (i == 0) begin
            // a register write while waiting for word two is refused
            mobl_host_i.xfer(1'b1, A_BANK, 32'h5a, rd, er);
            chk({31'h0, er}, 32'h1, "busy write");
            rdc(A_BANK, {24'h0, k}, "bank kept");
         end
         wr(A_INSTR, {16'h0, OPC_PTR2, kp[7:0]});
         idle_wait();
         ptr[i % 3] = kp;
         foreach (ptr[j]) begin
            rdc(A_PTR0 + 8'(4 * j), {20'h0, ptr[j]}, "ptr");
         end
         rdc(A_STATUS, {30'h0, st}, "flags after ptr");
      end
      // selector 3 is an error, cleared by writing 1
      wr(A_INSTR, {16'h0, OPC_PTR, 2'b11, 4'h0});
      idle_wait();
      rdc(A_STATUS, 32'h8, "err set");
      wr(A_STATUS, 32'h8);
      rdc(A_STATUS, 32'h0, "err cleared");
      // or-with-file and file-move with both destinations and banks
      for (int i = 0; i < 40; i++) begin
         op = 1'($urandom);
         d = (i < 4) ? 1'b1 : 1'($urandom);
         a = (i < 4) ? 1'b1 : 1'($urandom);
         f = (i % 2) ? 8'hff : 8'($urandom);
         if (i % 4 == 0) f = 8'h00;
         fv = (i == 5) ? 8'h00 : 8'($urandom);
         wv = (i == 5) ? 8'h00 : 8'($urandom);
         bk = 8'($urandom);
         if (eaddr(f, a, bk) == WREG_ADDR) f[0] = ~f[0];
         ad = eaddr(f, a, bk);
         ins2({OPC_BANK, bk}, {OPC_BANK, bk});
         wr(A_WREG, {24'h0, wv});
         mem_wr(ad, fv);
         res = op ? fv : (fv | wv);
         ins2({op ? OPC_FMOVE : OPC_IOR, d, a, f},
            {OPC_BANK, bk});
         st = {res[7], res == 8'h00};
         rdc(A_STATUS, {30'h0, st}, "zero/negative");
         rdc(A_WREG, {24'h0, d ? wv : res}, "w result");
         mem_chk(ad, d ? res : fv);
      end
      // memory move across the data space, w at either end
      for (int i = 0; i < 20; i++) begin
         s = 12'($urandom);
         t = 12'($urandom_range(12'heff, 0));
         v = 8'($urandom);
         if (i == 0) s = 12'h000;
         if (i == 0) t = 12'heff;
         if (i == 1) s = 12'hfff;
         if (i == 1) t = 12'h000;
         if (i == 2) s = WREG_ADDR;
         if (i == 3) t = WREG_ADDR;
         if (s == WREG_ADDR)
            wr(A_WREG, {24'h0, v});
         else
            mem_wr(s, v);
         ins2({OPC_MM1, s}, {OPC_MM2, t});
         rdc(A_STATUS, {30'h0, st}, "flags after move");
         if (t == WREG_ADDR)
            rdc(A_WREG, {24'h0, v}, "move to w");
         else
            mem_chk(t, v);
      end
      finish_test();
   end
endmodule // tb_move_or_bank_load_exec
`default_nettype wire
